/* tap_defs.svh */
// register offsets, field positions, reset values and limits of the tap detector
// assumes nothing; definitions only
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH
`define ADDR_TAP_CONFIG 8'h21
`define ADDR_TAP_SOURCE 8'h22
`define ADDR_TAP_THS_X 8'h23
`define ADDR_TAP_THS_Y 8'h24
`define ADDR_TAP_THS_Z 8'h25
`define CFG_DBL_ABORT 7
`define CFG_LATCH_EN 6
`define SRC_EVENT_ACTIVE 7
`define SRC_DOUBLE 3
`define RST_TAP_CONFIG 8'h00
`define RST_TAP_SOURCE 8'h00
`define RST_TAP_THS 7'h00
`define RST_BYTE 8'h00
// 4g at 0.063g per step
`define THS_LOW_NOISE_MAX 7'h3F
`endif

/* tap_pkg.sv */
// types shared by the tap detector modules
// assumes tap_defs.svh is available for constants
package tap_pkg;
    typedef logic signed [7:0] accel_t;
    typedef logic [6:0] ths_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LATENCY = 4'h2,
        ST_WINDOW = 4'h4,
        ST_SECOND = 4'h8
    } tap_state_e;
endpackage

/* tap_axis_if.sv */
// carrier between the tap controller and one axis pulse detector
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface tap_axis_if;
    tap_pkg::accel_t accel;
    logic sample_valid;
    tap_pkg::ths_t threshold;
    tap_pkg::byte_t time_limit;
    logic start;
    logic done;
    logic busy;
    logic polarity;
    modport det (input accel, sample_valid, threshold, time_limit, output start, done, busy, polarity);
    modport ctl (output accel, sample_valid, threshold, time_limit, input start, done, busy, polarity);
endinterface

/* tap_axis_detect.sv */
// one-axis pulse detector: finds a pulse above threshold and checks its width
// assumes samples arrive on the controller clock, qualified by sample_valid
`timescale 1ns/1ps
`include "tap_defs.svh"
module tap_axis_detect (
    input wire logic clk,
    input wire logic rst_n,
    tap_axis_if.det bus
);
    import tap_pkg::*;
    logic in_pulse_q, in_pulse_d;
    logic start_q, start_d;
    logic done_q, done_d;
    logic pol_q, pol_d;
    byte_t width_q, width_d;
    byte_t mag;
    logic above;

    // -128 maps to 8'h80, which is the right magnitude when read unsigned
    assign mag = bus.accel[7] ? byte_t'(-bus.accel) : byte_t'(bus.accel);
    assign above = mag > {1'b0, bus.threshold};

    always_comb begin
        in_pulse_d = in_pulse_q;
        width_d = width_q;
        pol_d = pol_q;
        start_d = 1'b0;
        done_d = 1'b0;
        if (bus.sample_valid) begin
            if (!in_pulse_q && above) begin
                in_pulse_d = 1'b1;
                start_d = 1'b1;
                width_d = 8'h01;
                pol_d = bus.accel[7];
            end else if (in_pulse_q && above) begin
                if (width_q != 8'hFF) begin
                    width_d = width_q + 8'h01;
                end
            end else if (in_pulse_q) begin
                in_pulse_d = 1'b0;
                done_d = width_q <= bus.time_limit;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_pulse_q <= 1'b0;
            width_q <= `RST_BYTE;
            pol_q <= 1'b0;
            start_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            in_pulse_q <= in_pulse_d;
            width_q <= width_d;
            pol_q <= pol_d;
            start_q <= start_d;
            done_q <= done_d;
        end
    end

    assign bus.start = start_q;
    assign bus.done = done_q;
    assign bus.busy = in_pulse_q;
    assign bus.polarity = pol_q;
endmodule

/* tap_pulse_detect_regs.sv */
// tap configuration, thresholds, single/double sequencing and source status
// assumes samples come in 0.063g steps on a fixed 8g scale, on CLOCK
`timescale 1ns/1ps
`include "tap_defs.svh"
// Behaviour
// - abort clear: latency pulses never cancel double
// - abort set: short latency pulse cancels double
// - latch enable holds flags until read
// - six per-axis single/double enables, reset zero
// - report only enabled axis and event type
// - event active bit set by any event
// - axis bits mark the axes that fired
// - double bit: zero single, one double
// - polarity bits: zero positive, one negative
// - latched active flag freezes other status bits
// - source read clears status and interrupt
// - seven-bit thresholds, bit seven reads zero
// - detection starts when magnitude exceeds threshold
// - threshold steps 0.063g on fixed 8g
// - low noise clamps threshold to 4g
// - thresholds reset to zero
// - latency interval ignores pulses after first
module tap_pulse_detect_regs (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic SAMPLE_VALID,
    input wire tap_pkg::accel_t ACCEL_X,
    input wire tap_pkg::accel_t ACCEL_Y,
    input wire tap_pkg::accel_t ACCEL_Z,
    input wire logic LOW_NOISE,
    input wire tap_pkg::byte_t TIME_LIMIT,
    input wire tap_pkg::byte_t LATENCY,
    input wire tap_pkg::byte_t WINDOW,
    input wire tap_pkg::byte_t REG_ADDR,
    input wire logic REG_WR,
    input wire tap_pkg::byte_t REG_WDATA,
    input wire logic REG_RD,
    output tap_pkg::byte_t REG_RDATA,
    output logic INT_TAP
);
    import tap_pkg::*;

    function automatic logic [2:0] tap_enables(input byte_t cfg, input logic dbl);
        tap_enables = dbl ? {cfg[5], cfg[3], cfg[1]} : {cfg[4], cfg[2], cfg[0]};
    endfunction

    function automatic ths_t ths_clamp(input ths_t ths, input logic low_noise);
        ths_clamp = (low_noise && ths > `THS_LOW_NOISE_MAX) ? `THS_LOW_NOISE_MAX : ths;
    endfunction

    byte_t cfg_q, cfg_d;
    byte_t src_q, src_d;
    byte_t rdata_q, rdata_d;
    ths_t ths_q [3];
    ths_t ths_d [3];
    tap_state_e state_q, state_d;
    byte_t cnt_q, cnt_d;
    logic [2:0] cand_q, cand_d;
    logic lat_start_q, lat_start_d;
    logic abort_q, abort_d;

    logic [2:0] sp_en, dp_en, start, done, busy, pol, first;
    accel_t acc [3];
    logic double_tap_abort, flag_latch_enable, src_clear, load;
    logic ev_valid, ev_dbl;
    logic [2:0] ev_axes, ev_pol;

    assign sp_en = tap_enables(cfg_q, 1'b0);
    assign dp_en = tap_enables(cfg_q, 1'b1);
    assign double_tap_abort = cfg_q[`CFG_DBL_ABORT];
    assign flag_latch_enable = cfg_q[`CFG_LATCH_EN];
    assign acc[0] = ACCEL_X;
    assign acc[1] = ACCEL_Y;
    assign acc[2] = ACCEL_Z;

    tap_axis_if ax [3] ();

    for (genvar i = 0; i < 3; i++) begin : g_axis
        assign ax[i].accel = acc[i];
        assign ax[i].sample_valid = SAMPLE_VALID;
        // threshold compares in 0.063g steps on the fixed 8g scale
        assign ax[i].threshold = ths_clamp(ths_q[i], LOW_NOISE);
        assign ax[i].time_limit = TIME_LIMIT;
        assign start[i] = ax[i].start;
        assign done[i] = ax[i].done;
        assign busy[i] = ax[i].busy;
        assign pol[i] = ax[i].polarity;
        tap_axis_detect u_det (
            .clk(CLOCK),
            .rst_n(RST_N),
            .bus(ax[i])
        );
    end

    // a pulse only counts on an axis with at least one event type enabled
    assign first = done & (sp_en | dp_en);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cand_d = cand_q;
        lat_start_d = lat_start_q;
        abort_d = abort_q;
        ev_valid = 1'b0;
        ev_dbl = 1'b0;
        ev_axes = 3'h0;
        ev_pol = 3'h0;
        case (state_q)
            ST_IDLE: begin
                if (|first) begin
                    if (|(first & sp_en)) begin
                        ev_valid = 1'b1;
                        ev_axes = first & sp_en;
                        ev_pol = pol & first & sp_en;
                    end
                    cand_d = first & dp_en;
                    lat_start_d = 1'b0;
                    abort_d = 1'b0;
                    cnt_d = LATENCY;
                    state_d = ST_LATENCY;
                end
            end
            ST_LATENCY: begin
                // pulses here never report; they only feed the abort option
                if (double_tap_abort && |(start & cand_q)) begin
                    lat_start_d = 1'b1;
                end
                if (double_tap_abort && lat_start_q && |(done & cand_q)) begin
                    abort_d = 1'b1;
                end
                if (cnt_q == 8'h00) begin
                    cnt_d = WINDOW;
                    // with abort clear a latency pulse leaves the candidate intact
                    state_d = (abort_d || cand_q == 3'h0) ? ST_IDLE : ST_WINDOW;
                end else if (SAMPLE_VALID) begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ST_WINDOW: begin
                if (|(start & cand_q)) begin
                    cand_d = start & cand_q;
                    state_d = ST_SECOND;
                end else if (cnt_q == 8'h00) begin
                    state_d = ST_IDLE;
                end else if (SAMPLE_VALID) begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ST_SECOND: begin
                // the second pulse must start inside the window but may end after it
                // a double enable cleared while the sequence runs drops the event
                if (|(done & cand_q & dp_en)) begin
                    ev_valid = 1'b1;
                    ev_dbl = 1'b1;
                    ev_axes = done & cand_q & dp_en;
                    ev_pol = pol & done & cand_q & dp_en;
                    state_d = ST_IDLE;
                end else if (!(|(busy & cand_q))) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            cnt_q <= `RST_BYTE;
            cand_q <= 3'h0;
            lat_start_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cand_q <= cand_d;
            lat_start_q <= lat_start_d;
            abort_q <= abort_d;
        end
    end

    assign src_clear = REG_RD && REG_ADDR == `ADDR_TAP_SOURCE;
    // a new event in the same cycle as the clearing read wins, so it is never lost
    assign load = ev_valid && (!flag_latch_enable || !src_q[`SRC_EVENT_ACTIVE] || src_clear);

    always_comb begin
        src_d = src_q;
        if (load) begin
            src_d = {1'b1, ev_axes, ev_dbl, ev_pol};
        end else if (src_clear) begin
            src_d = `RST_TAP_SOURCE;
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        ths_d = ths_q;
        if (REG_WR) begin
            case (REG_ADDR)
                `ADDR_TAP_CONFIG: cfg_d = REG_WDATA;
                `ADDR_TAP_THS_X: ths_d[0] = REG_WDATA[6:0];
                `ADDR_TAP_THS_Y: ths_d[1] = REG_WDATA[6:0];
                `ADDR_TAP_THS_Z: ths_d[2] = REG_WDATA[6:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (REG_RD) begin
            case (REG_ADDR)
                `ADDR_TAP_CONFIG: rdata_d = cfg_q;
                `ADDR_TAP_SOURCE: rdata_d = src_q;
                `ADDR_TAP_THS_X: rdata_d = {1'b0, ths_q[0]};
                `ADDR_TAP_THS_Y: rdata_d = {1'b0, ths_q[1]};
                `ADDR_TAP_THS_Z: rdata_d = {1'b0, ths_q[2]};
                default: rdata_d = `RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            cfg_q <= `RST_TAP_CONFIG;
            src_q <= `RST_TAP_SOURCE;
            rdata_q <= `RST_BYTE;
            ths_q[0] <= `RST_TAP_THS;
            ths_q[1] <= `RST_TAP_THS;
            ths_q[2] <= `RST_TAP_THS;
        end else begin
            cfg_q <= cfg_d;
            src_q <= src_d;
            rdata_q <= rdata_d;
            ths_q <= ths_d;
        end
    end

    assign REG_RDATA = rdata_q;
    // the interrupt is the active flag itself, so a clearing read drops both together
    assign INT_TAP = src_q[`SRC_EVENT_ACTIVE];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence s_first_pulse;
        state_q == ST_IDLE && (|first) && LATENCY != 8'h00;
    endsequence

    sequence s_latency_abort_end;
        state_q == ST_LATENCY && cnt_q == 8'h00 && abort_d;
    endsequence

    sequence s_plain_read;
        src_clear && !ev_valid;
    endsequence

    property p_no_abort_when_clear;
        state_q == ST_LATENCY && !double_tap_abort && !abort_q |=> !abort_q;
    endproperty
    a_no_abort_when_clear: assert property (p_no_abort_when_clear) else $error("abort set with abort option clear");

    property p_abort_ends_double;
        s_latency_abort_end |=> state_q == ST_IDLE ##1 !ev_dbl;
    endproperty
    a_abort_ends_double: assert property (p_abort_ends_double) else $error("double detection not suspended");

    property p_latch_hold;
        flag_latch_enable && src_q[`SRC_EVENT_ACTIVE] && !src_clear |=> src_q == $past(src_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched source status changed");

    property p_enable_gate;
        ev_valid |-> (ev_axes & ~(ev_dbl ? dp_en : sp_en)) == 3'h0 && ev_axes != 3'h0;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("event on a disabled axis or type");

    property p_event_sets_active;
        load |=> INT_TAP && src_q[6:4] == $past(ev_axes);
    endproperty
    a_event_sets_active: assert property (p_event_sets_active) else $error("event not shown in source");

    property p_axis_bits_only_by_event;
        !load && !src_clear |=> src_q == $past(src_q);
    endproperty
    a_axis_bits_only_by_event: assert property (p_axis_bits_only_by_event) else $error("source changed without cause");

    property p_double_bit;
        load |=> src_q[`SRC_DOUBLE] == $past(state_q == ST_SECOND);
    endproperty
    a_double_bit: assert property (p_double_bit) else $error("double bit does not match sequence");

    property p_polarity_bits;
        load |=> src_q[2:0] == ($past(pol) & src_q[6:4]);
    endproperty
    a_polarity_bits: assert property (p_polarity_bits) else $error("polarity bits wrong");

    property p_read_clears;
        s_plain_read |=> src_q == 8'h00 ##1 !INT_TAP || $past(load);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("source read did not clear");

    property p_threshold_top_bit;
        REG_RD && REG_ADDR != `ADDR_TAP_CONFIG && REG_ADDR != `ADDR_TAP_SOURCE |=> !REG_RDATA[7];
    endproperty
    a_threshold_top_bit: assert property (p_threshold_top_bit) else $error("threshold bit 7 read as one");

    property p_low_noise_clamp;
        LOW_NOISE |-> ax[0].threshold <= `THS_LOW_NOISE_MAX && ax[1].threshold <= `THS_LOW_NOISE_MAX
            && ax[2].threshold <= `THS_LOW_NOISE_MAX;
    endproperty
    a_low_noise_clamp: assert property (p_low_noise_clamp) else $error("threshold above 4g in low noise");

    property p_latency_entered;
        s_first_pulse |=> state_q == ST_LATENCY ##1 !ev_valid;
    endproperty
    a_latency_entered: assert property (p_latency_entered) else $error("latency interval skipped");

    property p_unlatched_follow;
        !flag_latch_enable && ev_valid |=> src_q[6:3] == {$past(ev_axes), $past(ev_dbl)};
    endproperty
    a_unlatched_follow: assert property (p_unlatched_follow) else $error("unlatched status not updated");

    property p_latched_freeze;
        flag_latch_enable && ev_valid && src_q[`SRC_EVENT_ACTIVE] && !src_clear |=> src_q == $past(src_q);
    endproperty
    a_latched_freeze: assert property (p_latched_freeze) else $error("frozen status overwritten");

    property p_regs_reset;
        !$past(RST_N) |-> cfg_q == `RST_TAP_CONFIG && ths_q[0] == `RST_TAP_THS && ths_q[1] == `RST_TAP_THS
            && ths_q[2] == `RST_TAP_THS;
    endproperty
    a_regs_reset: assert property (p_regs_reset) else $error("registers not zero after reset");

    property p_latency_length;
        state_q == ST_LATENCY && cnt_q != 8'h00 |=> state_q == ST_LATENCY;
    endproperty
    a_latency_length: assert property (p_latency_length) else $error("latency interval cut short");

    property p_threshold_write;
        REG_WR && REG_ADDR == `ADDR_TAP_THS_X |=> ths_q[0] == $past(REG_WDATA[6:0]);
    endproperty
    a_threshold_write: assert property (p_threshold_write) else $error("threshold write not stored");
endmodule

/* tap_host_model.sv */
// host-side register master for the tap detector
// assumes strobes are sampled on the rising clock edge and read data is registered on that same edge
`timescale 1ns/1ps
module tap_host_model (
    input wire logic clk,
    output tap_pkg::byte_t reg_addr,
    output logic reg_wr,
    output tap_pkg::byte_t reg_wdata,
    output logic reg_rd,
    input wire tap_pkg::byte_t reg_rdata
);
    import tap_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // strobes span one sampling edge; idle address and data are scrambled so stale values prove nothing
    task automatic write(input byte_t a, input byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic read(input byte_t a, output byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* tap_pulse_detect_regs_bench.sv */
// self-checking bench for the tap detector: register map, single/double taps, latch and thresholds
// assumes a host model on the register port and samples driven two clocks apart
`timescale 1ns/1ps
`include "tap_defs.svh"
module tap_pulse_detect_regs_bench;
    import tap_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic low_noise = 1'b0;
    accel_t ax = 8'h00, ay = 8'h00, az = 8'h00;
    byte_t time_limit = 8'h10, latency = 8'h04, window = 8'h08;
    byte_t reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, int_tap;
    int num_errors = 0, checked = 0, seed = 32'h336c_fef3;
    int mreg[5];
    int exp_q[$];

    always #50 clock = ~clock;

    tap_pulse_detect_regs tap_pulse_detect_regs_i (.CLOCK(clock), .RST_N(rst_n), .SAMPLE_VALID(sample_valid),
        .ACCEL_X(ax), .ACCEL_Y(ay), .ACCEL_Z(az), .LOW_NOISE(low_noise), .TIME_LIMIT(time_limit),
        .LATENCY(latency), .WINDOW(window), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .INT_TAP(int_tap));
    tap_host_model tap_host_model_i (.clk(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic check(input string name, input byte_t seen, input byte_t exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        tap_host_model_i.write(a, d);
        if (a == `ADDR_TAP_CONFIG) mreg[0] = d;
        else if (a >= `ADDR_TAP_THS_X && a <= `ADDR_TAP_THS_Z) mreg[a - `ADDR_TAP_CONFIG] = d & 8'h7F;
    endtask

    // source expectations come from the queue, mapped registers from the model, the rest read zero
    task automatic rd(input byte_t a);
        byte_t v;
        int e;
        tap_host_model_i.read(a, v);
        if (a == `ADDR_TAP_SOURCE) e = exp_q.size() ? exp_q.pop_front() : 0;
        else if (a >= `ADDR_TAP_CONFIG && a <= `ADDR_TAP_THS_Z) e = mreg[a - `ADDR_TAP_CONFIG];
        else e = 0;
        check($sformatf("reg_%h", a), v, byte_t'(e));
    endtask

    task automatic smp(input int axis, input int val);
        @(posedge clock);
        #1;
        sample_valid = 1'b1;
        ax = (axis == 0) ? accel_t'(val) : 8'h00;
        ay = (axis == 1) ? accel_t'(val) : 8'h00;
        az = (axis == 2) ? accel_t'(val) : 8'h00;
        @(posedge clock);
        #1;
        sample_valid = 1'b0;
        {ax, ay, az} = 24'($random(seed));
    endtask

    task automatic idle(input int n);
        repeat (n) smp(0, 0);
    endtask

    task automatic pulse(input int axis, input int val);
        smp(axis, val);
        smp(axis, 0);
    endtask

    task automatic expect_src(input int e);
        idle(8);
        exp_q.push_back(e);
        check("int_tap", {7'h00, int_tap}, byte_t'(e >> 7));
        rd(`ADDR_TAP_SOURCE);
        check("int_tap_after_read", {7'h00, int_tap}, 8'h00);
    endtask

    // layout: active, z/y/x axis, double, z/y/x polarity
    function automatic int src(input int axis, input int dbl, input int neg);
        return 8'h80 | (8'h10 << axis) | (dbl << 3) | (neg << axis);
    endfunction

    initial begin
        #2_000_000;
        num_errors++;
        results();
    end

    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        for (int a = 8'h20; a <= 8'h26; a++) rd(byte_t'(a));
        wr(`ADDR_TAP_CONFIG, 8'hFF);
        rd(`ADDR_TAP_CONFIG);
        for (int a = 8'h23; a <= 8'h25; a++) begin
            wr(byte_t'(a), byte_t'($random(seed)));
            rd(byte_t'(a));
            wr(byte_t'(a), 8'h0A);
        end
        wr(`ADDR_TAP_SOURCE, 8'hFF);
        wr(8'h26, 8'h55);
        rd(`ADDR_TAP_SOURCE);
        rd(8'h26);
        for (int a = 0; a < 3; a++) begin
            wr(`ADDR_TAP_CONFIG, byte_t'(1 << (2 * a)));
            for (int n = 0; n < 2; n++) begin
                pulse(a, n ? -10 : 10);
                expect_src(0);
                pulse(a, n ? -11 : 11);
                expect_src(src(a, 0, n));
                pulse((a + 1) % 3, 20);
                expect_src(0);
            end
        end
        for (int d = 0; d < 2; d++) begin
            wr(`ADDR_TAP_CONFIG, d ? 8'h82 : 8'h02);
            pulse(0, 30);
            // starts and ends inside the latency interval
            pulse(0, 30);
            idle(3);
            pulse(0, 30);
            expect_src(d ? 0 : src(0, 1, 0));
            idle(8);
        end
        wr(`ADDR_TAP_CONFIG, 8'h02);
        pulse(0, 30);
        expect_src(0);
        idle(8);
        for (int l = 0; l < 2; l++) begin
            wr(`ADDR_TAP_CONFIG, l ? 8'h55 : 8'h15);
            pulse(0, 30);
            idle(8);
            pulse(1, -30);
            expect_src(l ? src(0, 0, 0) : src(1, 0, 1));
        end
        // unlatched, so a pulse that slipped through the latency interval would overwrite the first
        wr(`ADDR_TAP_CONFIG, 8'h15);
        pulse(0, 30);
        pulse(1, -30);
        expect_src(src(0, 0, 0));
        wr(`ADDR_TAP_CONFIG, 8'h01);
        wr(`ADDR_TAP_THS_X, 8'h7F);
        low_noise = 1'b1;
        pulse(0, 63);
        expect_src(0);
        pulse(0, -64);
        expect_src(src(0, 0, 1));
        low_noise = 1'b0;
        pulse(0, 127);
        expect_src(0);
        wr(`ADDR_TAP_THS_X, 8'h28);
        repeat (4) begin
            pulse(0, $random(seed) % 41);
            expect_src(0);
        end
        // second reset in mid-run must bring every register back to zero
        @(posedge clock);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        mreg = '{default: 0};
        for (int a = 8'h21; a <= 8'h25; a++) rd(byte_t'(a));
        results();
    end
endmodule
